// File: rtl/debug_cause_select.v
/*
 * Picks the highest priority debug cause among those raised together.
 * Assumes all request inputs are on ref_clk and already qualified.
 */
`timescale 1ns/10ps
`default_nettype none
`include "debug_csr_defs.vh"

module debug_cause_select (
    input  wire       req_vec_trap,
    input  wire       req_dbkpt,
    input  wire       req_ext_debug,
    input  wire       req_tbuf_full,
    input  wire       req_ibkpt,
    input  wire       req_bkpt_instr,
    output reg        any_req,
    output reg  [2:0] cause
);

    // Fixed priority: vector trap, data bkpt, external, trace full, instr bkpt, bkpt instr
    always @* begin
        any_req = 1'b1;
        if (req_vec_trap) begin
            cause = `CAUSE_VEC_TRAP;
        end else if (req_dbkpt) begin
            cause = `CAUSE_DBKPT;
        end else if (req_ext_debug) begin
            cause = `CAUSE_EXT_DEBUG;
        end else if (req_tbuf_full) begin
            cause = `CAUSE_TBUF_FULL;
        end else if (req_ibkpt) begin
            cause = `CAUSE_IBKPT;
        end else if (req_bkpt_instr) begin
            cause = `CAUSE_BKPT_INSTR;
        end else begin
            cause   = `CAUSE_RESET;
            any_req = 1'b0;
        end
    end

endmodule // debug_cause_select

`default_nettype wire

// File: rtl/debug_control_status.v
/*
 * Debug control and status register with a software (coprocessor) port and
 * a JTAG port, plus the qualification of debug events against its fields.
 * Assumes: all inputs except trst_n come from ref_clk logic; trst_n is the
 * JTAG test reset from a pin and is synchronised here. Writes are one-cycle
 * strobes. Processor reset is the synchronous reset input.
 */
// Field ownership in short
//   Software side owns: global enable, sticky abort, entry cause,
//   trace mode and trace enable. The JTAG side only reads them.
//   JTAG side owns: halt select and the seven vector trap bits.
//   Software only reads them.
//
// Two resets, two owners
//   Processor reset restores the software-owned fields only. The
//   debugger must be able to arm a reset vector trap and halt mode
//   before or during a processor reset, so those fields survive it.
//   Test reset restores the JTAG-owned fields only, and it acts even
//   while processor reset is held, so power-up with reset high and trst_n low
//   leaves every field at a known value.
//
// Hazards a user must know
//   Test reset comes from a pin and passes two flops, so it takes
//   effect two to three edges late; a JTAG write inside that span is
//   overridden by it.
//   In halt mode software writes are dropped unless the core is in
//   its special debug state; nothing reports the dropped write.
//   A hardware event beats a software write to the same field in
//   the same cycle: losing a cause record is worse than losing a
//   write that software can simply repeat.
//   Reserved bits read as zero, which is one legal undefined value;
//   software must not rely on it.
//
// Event path
//   Raw event pulses are qualified against the enables, the
//   priority select picks one cause, and the exception pulse
//   leaves on the following edge together with the new cause.
`timescale 1ns/10ps
`default_nettype none
`include "debug_csr_defs.vh"

module debug_control_status (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        trst_n,
    input  wire        sw_wr,
    input  wire [31:0] sw_wdata,
    output wire [31:0] sw_rdata,
    input  wire        jtag_wr,
    input  wire [31:0] jtag_wdata,
    output wire [31:0] jtag_rdata,
    input  wire        sds_active,
    input  wire        data_abort_seen,
    input  wire [6:0]  vector_fetch,
    input  wire        ibkpt_hit,
    input  wire        dbkpt_hit,
    input  wire        bkpt_instr,
    input  wire        ext_debug_req,
    input  wire        tbuf_full,
    output reg         debug_exception,
    output reg         bkpt_as_loop,
    output reg         trace_active,
    output reg         trace_fill_once,
    output reg         halt_mode,
    output reg         debug_enabled
);

    // Field registers
    reg        global_debug_enable_reg;
    reg        global_debug_enable_next;
    reg        halt_sel_reg;
    reg        halt_sel_next;
    reg  [6:0] trap_reg;            // {fast_irq,normal_irq,data_abort,prefetch_abort,soft_interrupt,undef_instr,reset_vector}
    reg  [6:0] trap_next;
    reg        sticky_abort_flag_reg;
    reg        sticky_abort_flag_next;
    reg  [2:0] entry_cause_reg;
    reg  [2:0] entry_cause_next;
    reg        trace_mode_reg;
    reg        trace_mode_next;
    reg        trace_enable_reg;
    reg        trace_enable_next;
    reg        trst_meta_reg;
    reg        trst_sync_reg;
    wire       trst_active;
    wire [6:0] trap_hit;
    wire       sel_any;
    wire [2:0] sel_cause;
    wire       dbg_en;
    wire [31:0] image;

    // Test reset comes from a pin: two flops before use
    // No processor reset here: test reset must act while reset is held
    always @(posedge ref_clk) begin
        trst_meta_reg <= trst_n;
        trst_sync_reg <= trst_meta_reg;
    end
    assign trst_active = ~trst_sync_reg;

    // Short name for the qualifying enable
    assign dbg_en = global_debug_enable_reg;

    // Trap matched on vector fetch; only the reset trap ignores global enable
    genvar i;
    generate
        for (i = 0; i < 7; i = i + 1) begin : g_trap
            if (i == 0) begin : g_rst
                assign trap_hit[i] = trap_reg[i] & vector_fetch[i];
            end else begin : g_oth
                assign trap_hit[i] = trap_reg[i] & vector_fetch[i] & dbg_en;
            end
        end
    endgenerate

    // Priority among causes raised in the same cycle
    // Trace full only breaks in fill-once mode
    debug_cause_select debug_cause_select_inst (
        .req_vec_trap   (|trap_hit),
        .req_dbkpt      (dbkpt_hit & dbg_en),
        .req_ext_debug  (ext_debug_req & dbg_en),
        .req_tbuf_full  (tbuf_full & dbg_en & trace_mode_reg),
        .req_ibkpt      (ibkpt_hit & dbg_en),
        .req_bkpt_instr (bkpt_instr & dbg_en),
        .any_req        (sel_any),
        .cause          (sel_cause)
    );

    // Next-state of every field: reset, TRST, writes, then hardware events
    always @* begin
        global_debug_enable_next = global_debug_enable_reg;
        halt_sel_next            = halt_sel_reg;
        trap_next                = trap_reg;
        sticky_abort_flag_next   = sticky_abort_flag_reg;
        entry_cause_next         = entry_cause_reg;
        trace_mode_next          = trace_mode_reg;
        trace_enable_next        = trace_enable_reg;
        // JTAG-owned fields: test reset, then JTAG write; processor reset has no say
        if (trst_active) begin
            halt_sel_next = 1'b0;
            trap_next     = `TRAPS_ZERO;
        end else if (jtag_wr) begin
            halt_sel_next = jtag_wdata[`DCS_HALT_BIT];
            trap_next     = {jtag_wdata[`DCS_TRAP_FAST_BIT], jtag_wdata[`DCS_TRAP_NORM_BIT],
                             jtag_wdata[`DCS_TRAP_DABT_BIT], jtag_wdata[`DCS_TRAP_PABT_BIT],
                             jtag_wdata[`DCS_TRAP_SWI_BIT], jtag_wdata[`DCS_TRAP_UNDF_BIT],
                             jtag_wdata[`DCS_TRAP_RST_BIT]};
        end
        // Software-owned fields: processor reset, write, hardware events
        if (reset) begin
            global_debug_enable_next = 1'b0;
            sticky_abort_flag_next   = 1'b0;
            entry_cause_next         = `CAUSE_RESET;
            trace_mode_next          = 1'b0;
            trace_enable_next        = 1'b0;
        end else begin
            // Halt mode blocks software writes outside the special debug state
            if (sw_wr && (!halt_sel_reg || sds_active)) begin
                global_debug_enable_next = sw_wdata[`DCS_ENABLE_BIT];
                sticky_abort_flag_next   = sw_wdata[`DCS_STICKY_BIT];
                entry_cause_next         = sw_wdata[`DCS_CAUSE_HI:`DCS_CAUSE_LO];
                trace_mode_next          = sw_wdata[`DCS_MODE_BIT];
                trace_enable_next        = sw_wdata[`DCS_TEN_BIT];
            end
            // Hardware events win over a software write in the same cycle
            if (data_abort_seen && sds_active && halt_sel_reg) begin
                sticky_abort_flag_next = 1'b1;
            end
            if (sel_any) begin
                entry_cause_next  = sel_cause;
                trace_enable_next = 1'b0;
            end
        end
    end

    // Field state update
    always @(posedge ref_clk) begin
        global_debug_enable_reg <= global_debug_enable_next;
        halt_sel_reg            <= halt_sel_next;
        trap_reg                <= trap_next;
        sticky_abort_flag_reg   <= sticky_abort_flag_next;
        entry_cause_reg         <= entry_cause_next;
        trace_mode_reg          <= trace_mode_next;
        trace_enable_reg        <= trace_enable_next;
    end

    // Register image; reserved bits read zero, a legal undefined value
    assign image = {global_debug_enable_reg, halt_sel_reg, 6'h00,
                    trap_reg[6], trap_reg[5], 1'b0, trap_reg[4:0],
                    10'h000, sticky_abort_flag_reg, entry_cause_reg,
                    trace_mode_reg, trace_enable_reg};
    assign sw_rdata   = image;
    assign jtag_rdata = image;

    // Outputs to the core, all registered
    always @(posedge ref_clk) begin
        if (reset) begin
            debug_exception <= 1'b0;
            bkpt_as_loop    <= 1'b1;
            trace_active    <= 1'b0;
            trace_fill_once <= 1'b0;
            halt_mode       <= halt_sel_reg;
            debug_enabled   <= 1'b0;
        end else begin
            debug_exception <= sel_any;
            bkpt_as_loop    <= ~global_debug_enable_next;
            trace_active    <= trace_enable_next & global_debug_enable_next;
            trace_fill_once <= trace_mode_next;
            halt_mode       <= halt_sel_next;
            debug_enabled   <= global_debug_enable_next;
        end
    end

endmodule // debug_control_status

`default_nettype wire

// File: shared/debug_csr_defs.vh
/*
 * Field positions, reset values and entry cause codes of the debug control
 * and status register. Definitions only; included by its bare name.
 */
`ifndef DEBUG_CSR_DEFS_VH
`define DEBUG_CSR_DEFS_VH

`define DCS_ENABLE_BIT    31
`define DCS_HALT_BIT      30
`define DCS_TRAP_FAST_BIT 23
`define DCS_TRAP_NORM_BIT 22
`define DCS_TRAP_DABT_BIT 20
`define DCS_TRAP_PABT_BIT 19
`define DCS_TRAP_SWI_BIT  18
`define DCS_TRAP_UNDF_BIT 17
`define DCS_TRAP_RST_BIT  16
`define DCS_STICKY_BIT    5
`define DCS_CAUSE_HI      4
`define DCS_CAUSE_LO      2
`define DCS_MODE_BIT      1
`define DCS_TEN_BIT       0

`define CAUSE_RESET       3'h0
`define CAUSE_IBKPT       3'h1
`define CAUSE_DBKPT       3'h2
`define CAUSE_BKPT_INSTR  3'h3
`define CAUSE_EXT_DEBUG   3'h4
`define CAUSE_VEC_TRAP    3'h5
`define CAUSE_TBUF_FULL   3'h6

`define WORD_ZERO         32'h00000000
`define TRAPS_ZERO        7'h00

`endif

// File: tb/debug_csr_props.sv
/* Port checker for the debug control and status register.
   Assumes one ref_clk domain; bound onto debug_control_status. */
`timescale 1ns/10ps
`default_nettype none
module debug_csr_props (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        trst_n,
    input wire logic        sw_wr,
    input wire logic [31:0] sw_wdata,
    input wire logic [31:0] sw_rdata,
    input wire logic        jtag_wr,
    input wire logic [31:0] jtag_rdata,
    input wire logic        sds_active,
    input wire logic [6:0]  vector_fetch,
    input wire logic        dbkpt_hit,
    input wire logic        debug_exception,
    input wire logic        bkpt_as_loop
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Register image and access rights
    property p_rsv; (sw_rdata & 32'h3f20ffc0) == 32'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    property p_image; sw_rdata == jtag_rdata; endproperty
    a_image: assert property (p_image) else $error("port images differ");
    property p_sw_en; sw_wr && !(sw_rdata[30] && !sds_active) |=> sw_rdata[31] == $past(sw_wdata[31]); endproperty
    a_sw_en: assert property (p_sw_en) else $error("enable write lost");
    property p_jtag_ro; jtag_wr && !sw_wr |=> $stable(sw_rdata[31]) && $stable(sw_rdata[1]); endproperty
    a_jtag_ro: assert property (p_jtag_ro) else $error("jtag changed sw field");
    property p_sw_ro;
        sw_wr && !jtag_wr && trst_n && $past(trst_n) && $past(trst_n, 2) && $past(trst_n, 3)
        |=> $stable(sw_rdata[30:16]);
    endproperty
    a_sw_ro: assert property (p_sw_ro) else $error("sw changed jtag field");
    // Reset must act even while it is held, so no disable here
    property p_rst; disable iff (1'b0) reset |=> sw_rdata[5:0] == 6'h00 && !debug_exception && bkpt_as_loop; endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_trst; !trst_n [*6] |-> sw_rdata[30:16] == 15'h0000; endproperty
    a_trst: assert property (p_trst) else $error("test reset kept traps");
    // Event qualification
    property p_dbk; dbkpt_hit && sw_rdata[31] && vector_fetch == 7'h00 |=>
        debug_exception && sw_rdata[4:2] == 3'h2 && !sw_rdata[0]; endproperty
    a_dbk: assert property (p_dbk) else $error("data break entry wrong");
    property p_off; !sw_rdata[31] && !vector_fetch[0] |=> !debug_exception; endproperty
    a_off: assert property (p_off) else $error("debug while disabled");
    property p_vec; vector_fetch[0] && sw_rdata[16] |=> debug_exception && sw_rdata[4:2] == 3'h5; endproperty
    a_vec: assert property (p_vec) else $error("reset trap missed");
    c_exc: cover property (debug_exception);
    c_trst: cover property (!trst_n [*6]);
    c_both: cover property (sw_wr && jtag_wr);
endmodule // debug_csr_props
bind debug_control_status debug_csr_props debug_csr_props_inst (.ref_clk, .reset, .trst_n, .sw_wr, .sw_wdata,
    .sw_rdata, .jtag_wr, .jtag_rdata, .sds_active, .vector_fetch, .dbkpt_hit, .debug_exception, .bkpt_as_loop);
`default_nettype wire

// File: tb/debug_host_model.sv
/* Debugger host and debug software as seen by the register.
   Assumes the bench calls its tasks; test reset is low at power-up. */
`timescale 1ns/10ps
`default_nettype none
module debug_host_model (
    input wire logic         ref_clk,
    output var logic         sw_wr,
    output var logic  [31:0] sw_wdata,
    output var logic         jtag_wr,
    output var logic  [31:0] jtag_wdata,
    output var logic         trst_n
);
    // Power-up test reset, long enough for the synchroniser
    initial begin
        {sw_wr, jtag_wr, sw_wdata, jtag_wdata} = 66'h0;
        trst_n = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 trst_n = 1'b1;
    end
    // One-cycle write; data is scrambled after release, not held
    task put(input logic j, input logic [31:0] d);
        @(posedge ref_clk);
        #1 if (j) {jtag_wr, jtag_wdata} = {1'b1, d & 32'hc0df003f};
        else {sw_wr, sw_wdata} = {1'b1, d & 32'hc0df003f};
        @(posedge ref_clk);
        #1 {sw_wr, jtag_wr, sw_wdata, jtag_wdata} = {2'b00, ~sw_wdata, ~jtag_wdata};
    endtask
    task trst_pulse;
        @(posedge ref_clk);
        #1 trst_n = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 trst_n = 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule // debug_host_model
`default_nettype wire

// File: tb/tb_debug_control_status.sv
/* Self-checking bench for the debug control and status register.
   Assumes debug_host_model drives both write ports and test reset. */
`timescale 1ns/10ps
`default_nettype none
module tb_debug_control_status;
    logic ref_clk = 1'b0, reset = 1'b1, sds_active = 1'b0;
    logic [12:0] ev = 13'h0;
    logic sw_wr, jtag_wr, trst_n, exc, loop, tr_act, fill, halt, en;
    logic [31:0] sw_wdata, jtag_wdata, sw_rdata, jtag_rdata;
    int fails = 0, n_tests = 0;
    logic [12:0] evs [12] = '{13'hf80, 13'he80, 13'ha80, 13'h280, 13'h200,
        13'h40, 13'h20, 13'h10, 13'h8, 13'h4, 13'h2, 13'h1};
    logic [2:0] cz [12] = '{3'h2, 3'h4, 3'h6, 3'h1, 3'h3, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5};
    always #20 ref_clk = ~ref_clk;
    debug_host_model debug_host_model_inst (.ref_clk, .sw_wr, .sw_wdata, .jtag_wr, .jtag_wdata, .trst_n);
    debug_control_status debug_control_status_inst (.ref_clk, .reset, .trst_n, .sw_wr, .sw_wdata, .sw_rdata,
        .jtag_wr, .jtag_wdata, .jtag_rdata, .sds_active, .data_abort_seen(ev[12]), .vector_fetch(ev[6:0]),
        .ibkpt_hit(ev[7]), .dbkpt_hit(ev[8]), .bkpt_instr(ev[9]), .ext_debug_req(ev[10]), .tbuf_full(ev[11]),
        .debug_exception(exc), .bkpt_as_loop(loop), .trace_active(tr_act), .trace_fill_once(fill),
        .halt_mode(halt), .debug_enabled(en));
    task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Events are one-cycle pulses; the answer stands in the following cycle
    task pulse(input logic [12:0] v);
        @(posedge ref_clk);
        #1 ev = v;
        @(posedge ref_clk);
        #1 ev = 13'h0;
    endtask
    task t_access;
        check("after reset", {loop, sw_rdata}, {1'b1, 32'h0});
        debug_host_model_inst.put(1'b0, 32'h80000033);
        check("sw write", {en, tr_act, fill, jtag_rdata}, {3'b111, 32'h80000033});
        debug_host_model_inst.put(1'b1, 32'hffffffff);
        check("jtag write", {halt, sw_rdata}, {1'b1, 32'hc0df0033});
        debug_host_model_inst.put(1'b0, 32'h0);
        check("locked out", sw_rdata, 32'hc0df0033);
        sds_active = 1'b1;
        debug_host_model_inst.put(1'b0, 32'h8000002e);
        check("sds write", sw_rdata, 32'hc0df002e);
        @(posedge ref_clk);
        #1 reset = 1'b1;
        @(posedge ref_clk);
        #1 reset = 1'b0;
        check("cpu reset", sw_rdata, 32'h40df0000);
        $display("test access done");
    endtask
    task t_events;
        pulse(13'h102);
        check("disabled", {exc, loop}, 2'b01);
        pulse(13'h1);
        check("reset trap", {exc, sw_rdata}, {1'b1, 32'h40df0014});
        pulse(13'h1000);
        check("sticky", sw_rdata[5], 1'b1);
        for (int i = 0; i < 12; i++) begin
            debug_host_model_inst.put(1'b0, 32'h80000003);
            pulse(evs[i]);
            check("entry", {exc, sw_rdata}, {1'b1, 32'hc0df0002 | {27'h0, cz[i], 2'b00}});
        end
        $display("test events done");
    endtask
    task t_trst;
        debug_host_model_inst.trst_pulse;
        check("test reset", sw_rdata, 32'h80000016);
        $display("test trst done");
    endtask
    task complete_run;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 reset = 1'b0;
        t_access;
        t_events;
        t_trst;
        complete_run;
    end
    // Whole run is under a hundred cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        complete_run;
    end
endmodule // tb_debug_control_status
`default_nettype wire
